/* shared/resp_pkg.sv */
package resp_pkg;
	// register address, only VA 0x00 of the fault status space
	localparam logic [7:0] RESP_AFS_ASI = 8'h4C;
	localparam logic [63:0] RESP_AFS_VA = 64'h0000000000000000;
	localparam logic [63:0] RESP_AFS_RESET = 64'h0000000000000000;
	// field positions
	localparam int RESP_BIT_L2_WAY = 11;
	localparam int RESP_BIT_L1_WAY = 10;
	localparam int RESP_BIT_WR_BERR = 3;
	localparam int RESP_BIT_L2_UE = 1;
	localparam int RESP_BIT_L1D_UE = 0;
	// implemented bits; everything else reads zero
	localparam logic [63:0] RESP_AFS_MASK = 64'h0000000000000C0B;
	// trap-time correction value for the tick counter
	localparam logic [63:0] RESP_TICK_FIX = 64'h8000000000000000;
	// protected register indices
	localparam int RESP_NREG = 8;
	localparam int RESP_R_PC = 0;
	localparam int RESP_R_NPC = 1;
	localparam int RESP_R_PSTATE = 2;
	localparam int RESP_R_CWP = 3;
	localparam int RESP_R_ASI = 4;
	localparam int RESP_R_XAR = 5;
	localparam int RESP_R_TICK = 6;
	localparam int RESP_R_INTF = 7;
	// registers whose correction comes from the trap
	localparam logic [7:0] RESP_TRAP_FIX = 8'h7F;
	// registers whose error is only seen on instruction access
	localparam logic [7:0] RESP_ACC_ONLY = 8'h80;
	// registers whose error enters the fault trap
	localparam logic [7:0] RESP_TRAP_ENTRY = 8'h3F;
	// trap save slot indices
	localparam int RESP_NSAVE = 4;
	localparam int RESP_S_TPC = 0;
	localparam int RESP_S_TRAP_NEXT_PROGRAM_COUNTER = 1;
	localparam int RESP_S_TSTATE = 2;
	localparam int RESP_S_TRAP_EXTENDED_REGISTER = 3;
	typedef enum logic [1:0] {
		RESP_IDLE,
		RESP_FIX,
		RESP_HALT
	} resp_state_t;
endpackage

/* design/resp_unit.sv */
`timescale 1ns/1ps
// What this block does
// - hard power-on reset zeroes fault status
// - other resets keep fault status unchanged
// - status bits stay set until software writes a one to them
// - bit 11 set on l2 way removal
// - bit 10 set on l1 or tlb way removal
// - bit 3 set after erroring write completes
// - bit 1 set on l2 data uncorrectable
// - bit 0 set on l1d data uncorrectable
// - reserved bits read zero, writes ignored
// - read-after-errored-write may skip access fault
// - bus error reported in exactly one place
// - invalid space via physical access sets bit 3
// - error in last usable way halts fatally
// - corrected-data fault ignored unless status shows
// - core state urgent error enters fault trap
// - trap save copies carry parity error along
// - register file errors flagged only on access
// - whole register write clears latent error
// - trap processing rewrites trap-corrected registers
// - suspended tick error halts; fix loads 0x8000...
module resp_unit (
	input wire logic clk,
	input wire logic rst,
	input wire logic hard_por,
	input wire logic asi_rd,
	input wire logic asi_wr,
	input wire logic [7:0] asi_num,
	input wire logic [63:0] asi_va,
	input wire logic [63:0] asi_wdata,
	input wire logic l2_way_removed,
	input wire logic l1_tlb_way_removed,
	input wire logic last_way_error,
	input wire logic wr_bus_error_done,
	input wire logic wr_bus_error_is_timeout,
	input wire logic pa_invalid_space,
	input wire logic rd_bus_error,
	input wire logic rd_timeout,
	input wire logic l2_data_ue,
	input wire logic l1d_data_ue,
	input wire logic corr_fault_in,
	input wire logic corr_fault_l2,
	input wire logic [7:0] reg_parity_err,
	input wire logic [7:0] reg_full_write,
	input wire logic instr_access_intf,
	input wire logic float_access_err,
	input wire logic tick_suspended,
	input wire logic trap_save,
	input wire logic trap_done,
	output logic [63:0] asi_rdata,
	output logic asi_ack,
	output logic data_fault_berr,
	output logic data_fault_timeout,
	output logic corr_fault_take,
	output logic trap_entry,
	output logic integer_reg_urgent_fault,
	output logic float_reg_urgent_fault,
	output logic core_state_urgent_fault,
	output logic trap_save_urgent_fault,
	output logic core_urgent_fault,
	output logic fatal_halt,
	output logic [7:0] reg_fix_strobe,
	output logic tick_fix_load,
	output logic [63:0] tick_fix_value,
	output logic [3:0] save_parity_err
);

	// ****************************************
	// fault status register
	// ****************************************

	logic [63:0] afs_val;
	logic [63:0] afs_set;
	logic [63:0] afs_clr;
	logic hit;
	logic l2_way_removed_flag;
	logic l1_tlb_way_removed_flag;
	logic write_bus_error_flag;
	logic l2_data_uncorrectable_flag;
	logic l1d_data_uncorrectable_flag;

	assign hit = (asi_num == resp_pkg::RESP_AFS_ASI) && (asi_va == resp_pkg::RESP_AFS_VA);

	// event sources mapped onto their status bits
	always_comb begin
		afs_set = 64'h0000000000000000;
		afs_set[resp_pkg::RESP_BIT_L2_WAY] = l2_way_removed;
		afs_set[resp_pkg::RESP_BIT_L1_WAY] = l1_tlb_way_removed;
		// write errors land here only once the store has executed
		afs_set[resp_pkg::RESP_BIT_WR_BERR] = wr_bus_error_done | pa_invalid_space;
		afs_set[resp_pkg::RESP_BIT_L2_UE] = l2_data_ue;
		afs_set[resp_pkg::RESP_BIT_L1D_UE] = l1d_data_ue;
	end

	// write one clears, masked so reserved positions never move
	always_comb begin
		afs_clr = (asi_wr && hit) ? (asi_wdata & resp_pkg::RESP_AFS_MASK) : 64'h0000000000000000;
	end

	// one sticky cell per implemented bit; the generic reset is not wired in,
	// so logs survive warm resets for software to collect
	resp_w1c_bit #(
		.RST_VAL(resp_pkg::RESP_AFS_RESET[resp_pkg::RESP_BIT_L2_WAY])
	) i_l2_way_bit (
		.clk(clk),
		.hard_por(hard_por),
		.set_pulse(afs_set[resp_pkg::RESP_BIT_L2_WAY]),
		.clr_pulse(afs_clr[resp_pkg::RESP_BIT_L2_WAY]),
		.flag_r(l2_way_removed_flag)
	);

	resp_w1c_bit #(
		.RST_VAL(resp_pkg::RESP_AFS_RESET[resp_pkg::RESP_BIT_L1_WAY])
	) i_l1_way_bit (
		.clk(clk),
		.hard_por(hard_por),
		.set_pulse(afs_set[resp_pkg::RESP_BIT_L1_WAY]),
		.clr_pulse(afs_clr[resp_pkg::RESP_BIT_L1_WAY]),
		.flag_r(l1_tlb_way_removed_flag)
	);

	resp_w1c_bit #(
		.RST_VAL(resp_pkg::RESP_AFS_RESET[resp_pkg::RESP_BIT_WR_BERR])
	) i_wr_berr_bit (
		.clk(clk),
		.hard_por(hard_por),
		.set_pulse(afs_set[resp_pkg::RESP_BIT_WR_BERR]),
		.clr_pulse(afs_clr[resp_pkg::RESP_BIT_WR_BERR]),
		.flag_r(write_bus_error_flag)
	);

	resp_w1c_bit #(
		.RST_VAL(resp_pkg::RESP_AFS_RESET[resp_pkg::RESP_BIT_L2_UE])
	) i_l2_ue_bit (
		.clk(clk),
		.hard_por(hard_por),
		.set_pulse(afs_set[resp_pkg::RESP_BIT_L2_UE]),
		.clr_pulse(afs_clr[resp_pkg::RESP_BIT_L2_UE]),
		.flag_r(l2_data_uncorrectable_flag)
	);

	resp_w1c_bit #(
		.RST_VAL(resp_pkg::RESP_AFS_RESET[resp_pkg::RESP_BIT_L1D_UE])
	) i_l1d_ue_bit (
		.clk(clk),
		.hard_por(hard_por),
		.set_pulse(afs_set[resp_pkg::RESP_BIT_L1D_UE]),
		.clr_pulse(afs_clr[resp_pkg::RESP_BIT_L1D_UE]),
		.flag_r(l1d_data_uncorrectable_flag)
	);

	// reserved positions are tied low here and never stored
	always_comb begin
		afs_val = 64'h0000000000000000;
		afs_val[resp_pkg::RESP_BIT_L2_WAY] = l2_way_removed_flag;
		afs_val[resp_pkg::RESP_BIT_L1_WAY] = l1_tlb_way_removed_flag;
		afs_val[resp_pkg::RESP_BIT_WR_BERR] = write_bus_error_flag;
		afs_val[resp_pkg::RESP_BIT_L2_UE] = l2_data_uncorrectable_flag;
		afs_val[resp_pkg::RESP_BIT_L1D_UE] = l1d_data_uncorrectable_flag;
	end

	// register read port, one cycle latency
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			asi_rdata <= 64'h0000000000000000;
			asi_ack <= 1'b0;
		end else begin
			asi_ack <= asi_rd | asi_wr;
			// unmapped reads return zero
			asi_rdata <= (asi_rd && hit) ? (afs_val & resp_pkg::RESP_AFS_MASK) : 64'h0000000000000000;
		end
	end

	// ****************************************
	// bus error routing
	// ****************************************

	// read errors go to the data fault status, write errors to the
	// status bit above, so each event shows in one place only;
	// forwarded store-buffer reads never raise rd_bus_error here
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			data_fault_berr <= 1'b0;
			data_fault_timeout <= 1'b0;
		end else begin
			data_fault_berr <= rd_bus_error & ~rd_timeout;
			data_fault_timeout <= rd_timeout;
		end
	end

	// corrected-data fault only stands when status backs it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			corr_fault_take <= 1'b0;
		end else begin
			corr_fault_take <= corr_fault_in &
				(corr_fault_l2 ? afs_val[resp_pkg::RESP_BIT_L2_UE] : afs_val[resp_pkg::RESP_BIT_L1D_UE]);
		end
	end

	// ****************************************
	// register parity tracking
	// ****************************************

	logic [7:0] err_r;
	logic [7:0] err_nxt;
	logic [7:0] seen;
	logic [7:0] fix_r;
	logic [3:0] save_r;
	logic fix_go;
	resp_pkg::resp_state_t state_r;

	// interface file errors only count when an instruction touches them
	always_comb begin
		seen = reg_parity_err & ~resp_pkg::RESP_ACC_ONLY;
		seen[resp_pkg::RESP_R_INTF] = reg_parity_err[resp_pkg::RESP_R_INTF] & instr_access_intf;
	end

	// latent errors: new detections set, whole writes and trap fixes clear
	always_comb begin
		err_nxt = (err_r & ~reg_full_write & ~fix_r) | seen;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			err_r <= 8'h00;
		end else begin
			err_r <= err_nxt;
		end
	end

	// save slots inherit the parity state of their sources
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			save_r <= 4'h0;
		end else if (trap_save) begin
			save_r[resp_pkg::RESP_S_TPC] <= err_r[resp_pkg::RESP_R_PC];
			save_r[resp_pkg::RESP_S_TRAP_NEXT_PROGRAM_COUNTER] <= err_r[resp_pkg::RESP_R_NPC];
			save_r[resp_pkg::RESP_S_TSTATE] <= err_r[resp_pkg::RESP_R_PSTATE] | err_r[resp_pkg::RESP_R_ASI];
			save_r[resp_pkg::RESP_S_TRAP_EXTENDED_REGISTER] <= err_r[resp_pkg::RESP_R_XAR];
		end
	end

	assign save_parity_err = save_r;

	// ****************************************
	// urgent error classes and trap control
	// ****************************************

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			integer_reg_urgent_fault <= 1'b0;
			float_reg_urgent_fault <= 1'b0;
			core_state_urgent_fault <= 1'b0;
			trap_save_urgent_fault <= 1'b0;
			core_urgent_fault <= 1'b0;
		end else begin
			integer_reg_urgent_fault <= err_r[resp_pkg::RESP_R_ASI] | err_r[resp_pkg::RESP_R_INTF];
			float_reg_urgent_fault <= float_access_err;
			core_state_urgent_fault <= err_r[resp_pkg::RESP_R_PC] | err_r[resp_pkg::RESP_R_NPC] |
				err_r[resp_pkg::RESP_R_PSTATE] | err_r[resp_pkg::RESP_R_CWP];
			trap_save_urgent_fault <= |save_r;
			core_urgent_fault <= err_r[resp_pkg::RESP_R_XAR] | (err_r[resp_pkg::RESP_R_TICK] & ~tick_suspended);
		end
	end

	assign fix_go = (state_r == resp_pkg::RESP_IDLE) && trap_done;

	// trap entry, correction pass and fatal halt; halt is terminal
	// until reset since the core can no longer be trusted
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= resp_pkg::RESP_IDLE;
			trap_entry <= 1'b0;
			fatal_halt <= 1'b0;
			fix_r <= 8'h00;
			tick_fix_load <= 1'b0;
		end else begin
			trap_entry <= 1'b0;
			fix_r <= 8'h00;
			tick_fix_load <= 1'b0;
			case (state_r)
				resp_pkg::RESP_IDLE: begin
					if (last_way_error || (err_r[resp_pkg::RESP_R_TICK] && tick_suspended)) begin
						state_r <= resp_pkg::RESP_HALT;
						fatal_halt <= 1'b1;
					end else if (|(err_r & resp_pkg::RESP_TRAP_ENTRY)) begin
						trap_entry <= ~trap_done;
						if (fix_go) begin
							state_r <= resp_pkg::RESP_FIX;
						end
					end
				end
				resp_pkg::RESP_FIX: begin
					fix_r <= err_r & resp_pkg::RESP_TRAP_FIX;
					tick_fix_load <= err_r[resp_pkg::RESP_R_TICK];
					// a last-way error during the fix pass must not be lost
					if (last_way_error || (err_r[resp_pkg::RESP_R_TICK] && tick_suspended)) begin
						state_r <= resp_pkg::RESP_HALT;
						fatal_halt <= 1'b1;
					end else begin
						state_r <= resp_pkg::RESP_IDLE;
					end
				end
				resp_pkg::RESP_HALT: begin
					fatal_halt <= 1'b1;
				end
				default: begin
					state_r <= resp_pkg::RESP_IDLE;
				end
			endcase
		end
	end

	assign reg_fix_strobe = fix_r;

	// constant correction value, held in a flop for a clean output
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_fix_value <= 64'h0000000000000000;
		end else begin
			tick_fix_value <= resp_pkg::RESP_TICK_FIX;
		end
	end

endmodule // resp_unit

// sticky write-one-to-clear status cell, reset only by power-on
module resp_w1c_bit #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic clk,
	input wire logic hard_por,
	input wire logic set_pulse,
	input wire logic clr_pulse,
	output logic flag_r
);

	logic flag_nxt;

	// set beats clear so an error landing on the clearing write is kept
	always_comb begin
		flag_nxt = set_pulse | (flag_r & ~clr_pulse);
	end

	// no generic reset here on purpose; warm resets leave the record alone
	always_ff @(posedge clk) begin
		if (hard_por) begin
			flag_r <= RST_VAL;
		end else begin
			flag_r <= flag_nxt;
		end
	end

endmodule // resp_w1c_bit

/* bench/resp_unit_properties.sv */
`timescale 1ns/1ps
module resp_unit_properties (
	input wire logic clk,
	input wire logic rst,
	input wire logic hard_por,
	input wire logic asi_rd,
	input wire logic asi_wr,
	input wire logic [7:0] asi_num,
	input wire logic [63:0] asi_va,
	input wire logic [63:0] asi_wdata,
	input wire logic l2_way_removed,
	input wire logic l1_tlb_way_removed,
	input wire logic wr_bus_error_done,
	input wire logic pa_invalid_space,
	input wire logic l2_data_ue,
	input wire logic l1d_data_ue,
	input wire logic last_way_error,
	input wire logic [7:0] reg_parity_err,
	input wire logic trap_done,
	input wire logic [63:0] asi_rdata,
	input wire logic asi_ack,
	input wire logic trap_entry,
	input wire logic fatal_halt,
	input wire logic tick_fix_load,
	input wire logic [63:0] tick_fix_value
);
	// ****
	// decode
	// ****
	// a read under power-on clear is left out, its data is not defined
	wire hit = asi_num == resp_pkg::RESP_AFS_ASI && asi_va == resp_pkg::RESP_AFS_VA;
	wire rd_hit = asi_rd && hit && !hard_por;
	wire wr_hit = asi_wr && hit;
	wire any_set = l2_way_removed | l1_tlb_way_removed | wr_bus_error_done | pa_invalid_space | l2_data_ue
		| l1d_data_ue;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	AST_RSV: assert property (asi_ack |-> (asi_rdata & ~resp_pkg::RESP_AFS_MASK) == 64'h0)
		else $error("reserved status bit read as one");
	AST_L2_WAY: assert property ((l2_way_removed && !hard_por) ##1 rd_hit |=> asi_rdata[11])
		else $error("l2 way flag not set");
	AST_WR_BERR: assert property (
		((wr_bus_error_done || pa_invalid_space) && !hard_por) ##1 rd_hit |=> asi_rdata[3])
		else $error("write bus error flag not set");
	AST_POR: assert property ((hard_por && !any_set) ##1 rd_hit |=> asi_rdata == 64'h0)
		else $error("status not cleared by power-on");
	AST_STICKY: assert property ((rd_hit && !asi_wr) ##1 (!asi_wr && !hard_por) ##1 rd_hit
		|=> (asi_rdata & $past(asi_rdata, 2)) == $past(asi_rdata, 2)) else $error("status bit dropped");
	AST_W1C: assert property ((wr_hit && !any_set) ##1 (!any_set && !asi_wr) ##1 rd_hit
		|=> (asi_rdata & $past(asi_wdata, 3)) == 64'h0) else $error("write one did not clear");
	AST_TRAP: assert property (
		$rose(|(reg_parity_err & resp_pkg::RESP_TRAP_ENTRY)) ##1 !trap_done |=> trap_entry)
		else $error("no fault trap entry");
	AST_HALT: assert property (last_way_error |=> fatal_halt [*3])
		else $error("fatal halt missing");
	AST_TICK: assert property (tick_fix_load |-> tick_fix_value == resp_pkg::RESP_TICK_FIX)
		else $error("tick fix value wrong");
endmodule // resp_unit_properties
bind resp_unit resp_unit_properties i_resp_unit_properties (.clk, .rst, .hard_por, .asi_rd, .asi_wr, .asi_num,
	.asi_va, .asi_wdata, .l2_way_removed, .l1_tlb_way_removed, .wr_bus_error_done, .pa_invalid_space,
	.l2_data_ue, .l1d_data_ue, .last_way_error, .reg_parity_err, .trap_done, .asi_rdata, .asi_ack,
	.trap_entry, .fatal_halt, .tick_fix_load, .tick_fix_value);

/* bench/resp_unit_tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
	$display("[FAIL] %0t %h/%h", $time, a, b); end end
`define WT(c) begin cmp_count++; for (k = 0; k < 8 && (c) !== 1'b1; k++) @(negedge clk); \
	if ((c) !== 1'b1) begin error_cnt++; $display("[FAIL] %0t wait ran out", $time); final_report(); end end
module resp_unit_tb_top;
	// ****
	// dut
	// ****
	logic clk = 0, rst = 1, hard_por = 0, asi_rd = 0, asi_wr = 0, last_way_error = 0, corr_fault_in = 0;
	logic corr_fault_l2 = 0, trap_done = 0, wr_bus_error_is_timeout = 0, instr_access_intf = 0;
	logic tick_suspended = 0, trap_save = 0, tick_fix_load, asi_ack, data_fault_berr, data_fault_timeout;
	logic corr_fault_take, trap_entry, integer_reg_urgent_fault, float_reg_urgent_fault, fatal_halt;
	logic core_state_urgent_fault, trap_save_urgent_fault, core_urgent_fault;
	logic [7:0] asi_num = resp_pkg::RESP_AFS_ASI, reg_parity_err = 8'h00, reg_full_write = 8'h00, reg_fix_strobe;
	logic [63:0] asi_va = 64'h0, asi_wdata = 64'h0, asi_rdata, tick_fix_value;
	logic [3:0] save_parity_err;
	logic [5:0] ev = 6'h00;
	logic [2:0] mi = 3'h0;
	logic [63:0] bits [6] = '{64'h800, 64'h400, 64'h8, 64'h8, 64'h2, 64'h1};
	wire l2_way_removed, l1_tlb_way_removed, wr_bus_error_done, pa_invalid_space, l2_data_ue, l1d_data_ue;
	wire rd_bus_error, rd_timeout, float_access_err;
	wire [2:0] mo = {float_reg_urgent_fault, data_fault_timeout, data_fault_berr};
	int error_cnt = 0, cmp_count = 0, i, k;
	// event pulses come from one vector so a loop can walk them
	assign {l1d_data_ue, l2_data_ue, pa_invalid_space, wr_bus_error_done, l1_tlb_way_removed, l2_way_removed} = ev;
	assign {float_access_err, rd_timeout, rd_bus_error} = mi;
	always #4 clk = ~clk;
	resp_unit i_resp_unit (.clk, .rst, .hard_por, .asi_rd, .asi_wr, .asi_num, .asi_va, .asi_wdata,
		.l2_way_removed, .l1_tlb_way_removed, .last_way_error, .wr_bus_error_done, .wr_bus_error_is_timeout,
		.pa_invalid_space, .rd_bus_error, .rd_timeout, .l2_data_ue, .l1d_data_ue, .corr_fault_in,
		.corr_fault_l2, .reg_parity_err, .reg_full_write, .instr_access_intf, .float_access_err,
		.tick_suspended, .trap_save, .trap_done, .asi_rdata, .asi_ack, .data_fault_berr, .data_fault_timeout,
		.corr_fault_take, .trap_entry, .integer_reg_urgent_fault, .float_reg_urgent_fault,
		.core_state_urgent_fault, .trap_save_urgent_fault, .core_urgent_fault, .fatal_halt, .reg_fix_strobe,
		.tick_fix_load, .tick_fix_value, .save_parity_err);
	// register access, one extra idle cycle keeps strobes from re-asserting in one step
	task automatic rd(input logic [63:0] va, input logic [63:0] exp);
		asi_rd = 1;
		asi_va = va;
		@(negedge clk);
		asi_rd = 0;
		`CHK(asi_ack, 1'b1)
		`CHK(asi_rdata, exp)
		@(negedge clk);
	endtask
	task automatic wr(input logic [63:0] va, input logic [63:0] d);
		asi_wr = 1;
		asi_va = va;
		asi_wdata = d;
		@(negedge clk);
		asi_wr = 0;
		@(negedge clk);
	endtask
	task automatic final_report();
		$display("cmp %0d err %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (8) @(negedge clk);
		rst = 0;
		hard_por = 1;
		@(negedge clk);
		hard_por = 0;
		rd(64'h0, 64'h0);
		for (i = 0; i < 6; i++) begin
			ev[i] = 1'b1;
			@(negedge clk);
			ev = 6'h00;
			rd(64'h0, bits[i]);
			rd(64'h0, bits[i]);
			wr(64'h0, 64'h0);
			rd(64'h0, bits[i]);
			wr(64'h0, ~64'h0);
			rd(64'h0, 64'h0);
		end
		ev[0] = 1'b1;
		ev[0] <= #8 1'b0;
		wr(64'h0, 64'h800);
		rd(64'h0, 64'h800);
		rst = 1;
		@(negedge clk);
		rst = 0;
		@(negedge clk);
		rd(64'h0, 64'h800);
		wr(64'h8, 64'h800);
		asi_num = 8'h4D;
		rd(64'h0, 64'h0);
		asi_num = resp_pkg::RESP_AFS_ASI;
		rd(64'h8, 64'h0);
		rd(64'h0, 64'h800);
		for (i = 0; i < 4; i++) begin
			corr_fault_l2 = i[1];
			ev = {i[0] && !i[1], i[0] && i[1], 4'h0};
			@(negedge clk);
			ev = 6'h00;
			corr_fault_in = 1;
			@(negedge clk);
			corr_fault_in = 0;
			`CHK(corr_fault_take, i[0])
		end
		for (i = 0; i < 3; i++) begin
			mi[i] = 1'b1;
			`WT(mo[i])
			mi = 3'h0;
			@(negedge clk);
		end
		reg_parity_err = 8'h41;
		`WT(trap_entry)
		`CHK(core_urgent_fault, 1'b1)
		trap_done = 1;
		@(negedge clk);
		trap_done = 0;
		`WT(reg_fix_strobe === 8'h41)
		`CHK(tick_fix_load, 1'b1)
		`CHK(tick_fix_value, resp_pkg::RESP_TICK_FIX)
		reg_parity_err = 8'h00;
		@(negedge clk);
		// pc error, then a trap save copies it, then a full write clears it
		reg_parity_err = 8'h01;
		@(negedge clk);
		reg_parity_err = 8'h00;
		trap_save = 1;
		@(negedge clk);
		trap_save = 0;
		`CHK(save_parity_err, 4'h1)
		`CHK(core_state_urgent_fault, 1'b1)
		reg_full_write = 8'h01;
		@(negedge clk);
		reg_full_write = 8'h00;
		`CHK(trap_save_urgent_fault, 1'b1)
		@(negedge clk);
		`CHK(core_state_urgent_fault, 1'b0)
		// register file error only counts on instruction access
		reg_parity_err = 8'h80;
		repeat (2) @(negedge clk);
		`CHK(integer_reg_urgent_fault, 1'b0)
		instr_access_intf = 1;
		repeat (2) @(negedge clk);
		`CHK(integer_reg_urgent_fault, 1'b1)
		reg_parity_err = 8'h00;
		instr_access_intf = 0;
		last_way_error = 1;
		@(negedge clk);
		last_way_error = 0;
		`WT(fatal_halt)
		final_report();
	end
endmodule // resp_unit_tb_top
